// >>> include/data_move_pkg.sv
/*
  Shared types and constants for the data-transfer instruction executor:
  opcodes, operand field layout, state set, memory request carriers.
  Assumes a byte-wide instruction stream offered one byte per request.
*/
package data_move_pkg;
  localparam logic [7:0] OP_BIT_TO_CARRY  = 8'hA2;
  localparam logic [7:0] OP_CARRY_TO_BIT  = 8'h92;
  localparam logic [7:0] OP_PTR_LOAD      = 8'h90;
  localparam logic [7:0] OP_IMM_TO_DIRECT = 8'h75;
  localparam logic [7:0] OP_ACC_TO_DIRECT = 8'hF5;
  localparam logic [7:0] OP_DIRECT_MOVE   = 8'h85;
  localparam logic [7:0] OP_LOOKUP_PTR    = 8'h93;
  localparam logic [7:0] OP_LOOKUP_PC     = 8'h83;
  localparam logic [7:0] OP_EXT_WRITE     = 8'hF0;
  localparam logic [4:0] GRP_IMM_TO_REG   = 5'h0F;
  localparam logic [4:0] GRP_ACC_TO_REG   = 5'h1F;
  localparam logic [4:0] GRP_DIR_TO_REG   = 5'h15;
  localparam logic [4:0] GRP_REG_TO_DIR   = 5'h11;
  localparam logic [6:0] GRP_IND_TO_DIR   = 7'h43;
  localparam int         REG_IDX_W        = 3;
  localparam int         BANK_DEPTH       = 8;
  localparam logic [7:0] BIT_BYTE_BASE    = 8'h20;
  localparam logic [7:0] BIT_SFR_MASK     = 8'hF8;
  localparam int         BIT_POS_W        = 3;
  localparam logic [7:0] BYTE_ZERO        = 8'h00;
  localparam logic [15:0] WORD_ZERO       = 16'h0000;
  localparam logic [15:0] PC_STEP         = 16'h0001;

  typedef enum {
    ST_OPCODE, ST_OPERAND1, ST_OPERAND2, ST_READ, ST_WAIT, ST_WRITE, ST_CODE, ST_EXT
  } state_t;

  typedef struct packed {
    logic       en;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iram_req_t;

  typedef struct packed {
    logic       en;
    logic       wr;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] wdata;
  } xbus_req_t;
endpackage

// >>> tb/data_move_instruction_exec_test.sv
/*
  Self-checking random testbench for the data-transfer executor.
  Assumes mem_partner as memory model and the package opcode constants.
*/
`timescale 1ns/100ps
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module data_move_instruction_exec_test;
  logic                     CLOCK = 1'b0;
  logic                     RESETN = 1'b0;
  logic                     INSTR_VALID = 1'b0;
  logic [7:0]               INSTR_BYTE = 8'h00;
  logic [15:0]              PC_IN = 16'h0000;
  logic                     slow = 1'b0;
  logic [7:0]               IRAM_RDATA;
  logic                     CODE_VALID;
  logic [7:0]               CODE_DATA;
  logic                     INSTR_READY;
  logic                     DONE;
  data_move_pkg::iram_req_t IRAM;
  data_move_pkg::xbus_req_t XBUS;
  logic                     CODE_REQ;
  logic [7:0]               ACC;
  logic                     CARRY;
  logic [15:0]              WIDE_POINTER_REG;
  logic [15:0]              PC_OUT;
  logic                     PC_LOAD;
  int                       miscompares = 0;
  int                       check_count = 0;
  logic [15:0]              p;
  logic [15:0]              pc;
  logic [7:0]               a, d, s, v, e, ba, bb;
  logic [2:0]               r;
  logic                     c;

  always #2 CLOCK = ~CLOCK;

  data_move_exec data_move_exec_inst (.CLOCK(CLOCK), .RESETN(RESETN), .INSTR_VALID(INSTR_VALID),
    .INSTR_BYTE(INSTR_BYTE), .PC_IN(PC_IN), .IRAM_RDATA(IRAM_RDATA), .CODE_VALID(CODE_VALID),
    .CODE_DATA(CODE_DATA), .INSTR_READY(INSTR_READY), .DONE(DONE), .IRAM(IRAM), .XBUS(XBUS),
    .CODE_REQ(CODE_REQ), .ACC(ACC), .CARRY(CARRY), .WIDE_POINTER_REG(WIDE_POINTER_REG),
    .PC_OUT(PC_OUT), .PC_LOAD(PC_LOAD));

  mem_partner mem_partner_inst (.clock(CLOCK), .resetn(RESETN), .slow(slow), .iram(IRAM), .xbus(XBUS),
    .code_req(CODE_REQ), .iram_rdata(IRAM_RDATA), .code_valid(CODE_VALID), .code_data(CODE_DATA));

  function automatic logic [7:0] code_byte(input logic [15:0] addr);
    return addr[15:8] ^ addr[7:0] ^ 8'hA5;
  endfunction

  function automatic logic [7:0] bit_byte(input logic [7:0] bit_addr);
    return bit_addr[7] ? (bit_addr & data_move_pkg::BIT_SFR_MASK)
                       : data_move_pkg::BIT_BYTE_BASE + {4'h0, bit_addr[6:3]};
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d, miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic hang();
    miscompares++;
    end_of_test();
  endtask

  // request held from just after an edge until the edge that samples ready high
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    INSTR_VALID = 1'b1;
    INSTR_BYTE  = b;
    while (INSTR_READY !== 1'b1 && n < 50) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    if (n >= 50) hang();
    @(posedge CLOCK);
    #1;
  endtask

  // lat of zero skips the latency compare: lookups depend on the memory's answer
  task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                     input int nb, input int lat);
    int k;
    send(b0);
    if (nb > 1) send(b1);
    if (nb > 2) send(b2);
    INSTR_VALID = 1'b0;
    INSTR_BYTE  = 8'($urandom);
    // the edge that took the last byte counts as cycle one; a one-cycle DONE already stands here
    k = 1;
    while (DONE !== 1'b1 && k < 60) begin
      @(posedge CLOCK);
      #1;
      k++;
    end
    if (k >= 60) hang();
    if (lat > 0) `CHECK(k, lat)
    // memory writes issued with DONE land one edge later
    @(posedge CLOCK);
    #1;
  endtask

  initial begin
    void'($urandom(32'h2267));
    repeat (4) @(posedge CLOCK);
    #1;
    RESETN = 1'b1;
    for (int i = 0; i < 8; i++) begin
      slow = i[0];
      p = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
      run(data_move_pkg::OP_PTR_LOAD, p[15:8], p[7:0], 3, 2);
      `CHECK(WIDE_POINTER_REG, p)
      a = ACC;
      c = CARRY;
      run(data_move_pkg::OP_LOOKUP_PTR, 8'h00, 8'h00, 1, 0);
      `CHECK(mem_partner_inst.lookup_addr, p + {8'h00, a})
      `CHECK(ACC, code_byte(p + {8'h00, a}))
      `CHECK(CARRY, c)
      pc = (i == 0) ? 16'hFFFF : 16'($urandom);
      PC_IN = pc;
      a = ACC;
      run(data_move_pkg::OP_LOOKUP_PC, 8'h00, 8'h00, 1, 0);
      `CHECK(PC_OUT, pc + 16'h0001)
      `CHECK(mem_partner_inst.lookup_addr, pc + 16'h0001 + {8'h00, a})
      `CHECK(ACC, code_byte(pc + 16'h0001 + {8'h00, a}))
      d = 8'($urandom);
      run(data_move_pkg::OP_ACC_TO_DIRECT, d, 8'h00, 2, 1);
      `CHECK(mem_partner_inst.mem[d], ACC)
      run(data_move_pkg::OP_EXT_WRITE, 8'h00, 8'h00, 1, 2);
      `CHECK(mem_partner_inst.ext_addr, p)
      `CHECK(mem_partner_inst.ext_data, ACC)
      v = 8'($urandom);
      d = 8'($urandom);
      run(data_move_pkg::OP_IMM_TO_DIRECT, d, v, 3, 2);
      `CHECK(mem_partner_inst.mem[d], v)
      r = 3'($urandom);
      v = 8'($urandom);
      run({data_move_pkg::GRP_IMM_TO_REG, r}, v, 8'h00, 2, 1);
      run({data_move_pkg::GRP_REG_TO_DIR, r}, d, 8'h00, 2, 2);
      `CHECK(mem_partner_inst.mem[d], v)
      run({data_move_pkg::GRP_ACC_TO_REG, r}, 8'h00, 8'h00, 1, 1);
      run({data_move_pkg::GRP_REG_TO_DIR, r}, d, 8'h00, 2, 2);
      `CHECK(mem_partner_inst.mem[d], ACC)
      s = 8'($urandom);
      e = mem_partner_inst.mem[s];
      run({data_move_pkg::GRP_DIR_TO_REG, r}, s, 8'h00, 2, 3);
      run({data_move_pkg::GRP_REG_TO_DIR, r}, d, 8'h00, 2, 2);
      `CHECK(mem_partner_inst.mem[d], e)
      s = 8'($urandom);
      d = 8'($urandom);
      e = mem_partner_inst.mem[s];
      run(data_move_pkg::OP_DIRECT_MOVE, d, s, 3, 3); // destination byte first, source byte last
      `CHECK(mem_partner_inst.mem[d], e)
      s = 8'($urandom);
      run({data_move_pkg::GRP_IMM_TO_REG, 2'b00, r[0]}, s, 8'h00, 2, 1);
      e = mem_partner_inst.mem[s];
      run({data_move_pkg::GRP_IND_TO_DIR, r[0]}, d, 8'h00, 2, 3);
      `CHECK(mem_partner_inst.mem[d], e)
      ba = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      e = mem_partner_inst.mem[bit_byte(ba)];
      a = ACC;
      run(data_move_pkg::OP_BIT_TO_CARRY, ba, 8'h00, 2, 2);
      `CHECK(CARRY, e[ba[2:0]])
      `CHECK(ACC, a)
      ba = (i == 0) ? 8'h7F : 8'($urandom);
      bb = bit_byte(ba);
      e = mem_partner_inst.mem[bb];
      e[ba[2:0]] = CARRY;
      run(data_move_pkg::OP_CARRY_TO_BIT, ba, 8'h00, 2, 3);
      `CHECK(mem_partner_inst.mem[bb], e)
    end
    end_of_test();
  end
endmodule

// >>> tb/mem_partner.sv
/*
  Behavioural model of internal data memory, code memory and external data
  memory facing the data-transfer executor. Internal memory reads answer
  while the request stands; idle read data toggle.
  Assumes the request carriers of data_move_pkg and one shared clock.
*/
`timescale 1ns/100ps
module mem_partner (
  input  wire logic                     clock,
  input  wire logic                     resetn,
  input  wire logic                     slow,
  input  wire data_move_pkg::iram_req_t iram,
  input  wire data_move_pkg::xbus_req_t xbus,
  input  wire logic                     code_req,
  output logic      [7:0]               iram_rdata,
  output logic                          code_valid,
  output logic      [7:0]               code_data
);
  logic [7:0]  mem [256];
  logic [15:0] lookup_addr;
  logic [15:0] ext_addr;
  logic [7:0]  ext_data;
  logic [7:0]  idle_rdata;
  int          wait_count;
  logic        answered;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 256; i++) mem[i] <= 8'(i * 37 + 11);
      idle_rdata  <= 8'h00;
      code_valid  <= 1'b0;
      code_data   <= 8'h00;
      wait_count  <= 0;
      answered    <= 1'b0;
      lookup_addr <= 16'h0000;
      ext_addr    <= 16'h0000;
      ext_data    <= 8'h00;
    end else begin
      // idle lines toggle so a stale value is never mistaken for an answer
      idle_rdata <= ~idle_rdata;
      code_data  <= ~code_data;
      code_valid <= 1'b0;
      if (iram.en && iram.wr) mem[iram.addr] <= iram.wdata;
      if (xbus.en && xbus.wr) begin
        ext_addr <= {xbus.hi, xbus.lo};
        ext_data <= xbus.wdata;
      end
      if (!code_req) begin
        wait_count <= 0;
        answered   <= 1'b0;
      end else if (!answered) begin
        if (wait_count >= (slow ? 3 : 0)) begin
          code_valid  <= 1'b1;
          code_data   <= xbus.hi ^ xbus.lo ^ 8'hA5;
          lookup_addr <= {xbus.hi, xbus.lo};
          answered    <= 1'b1;
        end else begin
          wait_count <= wait_count + 1;
        end
      end
    end
  end

  // the executor takes read data at the edge that ends its one-cycle request
  assign iram_rdata = (iram.en && !iram.wr) ? mem[iram.addr] : idle_rdata;
endmodule

// >>> verilog/bank_regs.sv
/*
  Eight-entry bank register store, one write port, two read ports.
  Read data come out of registers, so a read is seen one cycle later.
*/
`timescale 1ns/100ps
module bank_regs #(
  parameter int DEPTH = data_move_pkg::BANK_DEPTH,
  parameter int IDX_W = data_move_pkg::REG_IDX_W
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             we,
  input  wire logic [IDX_W-1:0] widx,
  input  wire logic [7:0]       wdata,
  input  wire logic [IDX_W-1:0] ridx_a,
  input  wire logic [IDX_W-1:0] ridx_b,
  output logic      [7:0]       rdata_a,
  output logic      [7:0]       rdata_b
);
  // the decode hands over a full index, so every index must name a cell
  if (DEPTH != (1 << IDX_W)) begin : gen_bad_depth
    $error("bank depth must equal 2**IDX_W");
  end

  logic [7:0] mem [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gen_cell
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          mem[g] <= data_move_pkg::BYTE_ZERO;
        end else if (we && widx == IDX_W'(g)) begin
          mem[g] <= wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_a <= data_move_pkg::BYTE_ZERO;
      rdata_b <= data_move_pkg::BYTE_ZERO;
    end else begin
      rdata_a <= mem[ridx_a];
      rdata_b <= mem[ridx_b];
    end
  end
endmodule

// >>> verilog/data_move_exec.sv
/*
  Executor for the data-transfer instruction group of an 8-bit core:
  bit/carry moves, pointer and bank register loads, direct and indirect
  moves into internal data memory, code table lookups, and external writes
  through the wide pointer.
  Assumes: one opcode or operand byte per accepted INSTR_VALID, internal
  memory answers a read with IRAM_RDATA while the registered request stands,
  so the data are taken at the edge after the request is issued,
  code memory answers on CODE_VALID, and the external write completes in
  the cycle its strobe is shown.
*/
`timescale 1ns/100ps
module data_move_exec (
  input  wire logic                    CLOCK,
  input  wire logic                    RESETN,
  input  wire logic                    INSTR_VALID,
  input  wire logic [7:0]              INSTR_BYTE,
  input  wire logic [15:0]             PC_IN,
  input  wire logic [7:0]              IRAM_RDATA,
  input  wire logic                    CODE_VALID,
  input  wire logic [7:0]              CODE_DATA,
  output logic                         INSTR_READY,
  output logic                         DONE,
  output data_move_pkg::iram_req_t     IRAM,
  output data_move_pkg::xbus_req_t     XBUS,
  output logic                         CODE_REQ,
  output logic [7:0]                   ACC,
  output logic                         CARRY,
  output logic [15:0]                  WIDE_POINTER_REG,
  output logic [15:0]                  PC_OUT,
  output logic                         PC_LOAD
);
  typedef struct packed {
    data_move_pkg::state_t   st;
    logic [7:0]              opcode;
    logic [7:0]              op1;
    logic [7:0]              val;
    logic [7:0]              acc;
    logic                    carry;
    logic [15:0]             ptr;
    logic [15:0]             pc;
    logic                    pc_load;
    logic                    ready;
    logic                    done;
    data_move_pkg::iram_req_t iram;
    data_move_pkg::xbus_req_t xbus;
    logic                    code_req;
    logic                    bank_we;
    logic [2:0]              bank_widx;
    logic [7:0]              bank_wdata;
  } core_t;

  core_t cur;
  core_t next_cur;
  logic [7:0] bank_a;
  logic [7:0] bank_b;
  logic [2:0] sel_idx;
  logic [2:0] ind_idx;
  logic [7:0] bit_byte;
  logic [2:0] bit_pos;

  // register index comes from the opcode for every banked form
  assign sel_idx = (cur.st == data_move_pkg::ST_OPCODE) ? INSTR_BYTE[2:0] : cur.opcode[2:0];
  // follows the held opcode once it is taken, so an operand gap cannot change the pointer register
  assign ind_idx = {2'b00, sel_idx[0]};

  bank_regs #(
    .DEPTH (data_move_pkg::BANK_DEPTH),
    .IDX_W (data_move_pkg::REG_IDX_W)
  ) u_bank (
    .clock   (CLOCK),
    .resetn  (RESETN),
    .we      (cur.bank_we),
    .widx    (cur.bank_widx),
    .wdata   (cur.bank_wdata),
    .ridx_a  (sel_idx),
    .ridx_b  (ind_idx),
    .rdata_a (bank_a),
    .rdata_b (bank_b)
  );

  // bit address split: low 128 bits live in bytes 20h..2Fh, upper in SFRs
  function automatic logic [7:0] bit_to_byte(input logic [7:0] ba);
    logic [7:0] r;
    r = ba[7] ? (ba & data_move_pkg::BIT_SFR_MASK) : (data_move_pkg::BIT_BYTE_BASE + {4'h0, ba[6:3]});
    return r;
  endfunction

  assign bit_byte = bit_to_byte(cur.op1);
  assign bit_pos  = cur.op1[data_move_pkg::BIT_POS_W-1:0];

  always_comb begin
    next_cur          = cur;
    next_cur.done     = 1'b0;
    next_cur.bank_we  = 1'b0;
    next_cur.pc_load  = 1'b0;
    next_cur.iram.en  = 1'b0;
    next_cur.iram.wr  = 1'b0;
    next_cur.xbus.en  = 1'b0;
    next_cur.xbus.wr  = 1'b0;
    next_cur.code_req = 1'b0;
    case (cur.st)
      data_move_pkg::ST_OPCODE: begin
        next_cur.ready = 1'b1;
        if (INSTR_VALID && cur.ready) begin
          next_cur.opcode = INSTR_BYTE;
          next_cur.pc     = PC_IN;
          if (INSTR_BYTE[7:3] == data_move_pkg::GRP_ACC_TO_REG) begin
            next_cur.bank_we    = 1'b1;
            next_cur.bank_widx  = INSTR_BYTE[2:0];
            next_cur.bank_wdata = cur.acc;
            next_cur.done       = 1'b1;
          end else if (INSTR_BYTE == data_move_pkg::OP_LOOKUP_PTR) begin
            next_cur.ready    = 1'b0;
            next_cur.xbus.hi  = cur.ptr[15:8] + 8'((16'(cur.acc) + {8'h00, cur.ptr[7:0]}) >> 8);
            next_cur.xbus.lo  = cur.ptr[7:0] + cur.acc;
            next_cur.code_req = 1'b1;
            next_cur.st       = data_move_pkg::ST_CODE;
          end else if (INSTR_BYTE == data_move_pkg::OP_LOOKUP_PC) begin
            next_cur.ready    = 1'b0;
            next_cur.pc       = PC_IN + data_move_pkg::PC_STEP;
            next_cur.pc_load  = 1'b1;
            {next_cur.xbus.hi, next_cur.xbus.lo} = PC_IN + data_move_pkg::PC_STEP + 16'(cur.acc);
            next_cur.code_req = 1'b1;
            next_cur.st       = data_move_pkg::ST_CODE;
          end else if (INSTR_BYTE == data_move_pkg::OP_EXT_WRITE) begin
            next_cur.ready      = 1'b0;
            next_cur.xbus.en    = 1'b1;
            next_cur.xbus.wr    = 1'b1;
            next_cur.xbus.hi    = cur.ptr[15:8];
            next_cur.xbus.lo    = cur.ptr[7:0];
            next_cur.xbus.wdata = cur.acc;
            next_cur.st         = data_move_pkg::ST_EXT;
          end else if (INSTR_BYTE[7:1] == data_move_pkg::GRP_IND_TO_DIR) begin
            next_cur.st = data_move_pkg::ST_OPERAND1; // register value read next cycle
          end else begin
            next_cur.st = data_move_pkg::ST_OPERAND1;
          end
        end
      end
      data_move_pkg::ST_OPERAND1: begin
        next_cur.ready = 1'b1;
        if (INSTR_VALID && cur.ready) begin
          next_cur.op1 = INSTR_BYTE;
          next_cur.st  = data_move_pkg::ST_OPCODE;
          if (cur.opcode[7:3] == data_move_pkg::GRP_IMM_TO_REG) begin
            next_cur.bank_we    = 1'b1;
            next_cur.bank_widx  = cur.opcode[2:0];
            next_cur.bank_wdata = INSTR_BYTE;
            next_cur.done       = 1'b1;
          end else if (cur.opcode == data_move_pkg::OP_ACC_TO_DIRECT) begin
            next_cur.iram = '{en: 1'b1, wr: 1'b1, addr: INSTR_BYTE, wdata: cur.acc};
            next_cur.done = 1'b1;
          end else if (cur.opcode[7:3] == data_move_pkg::GRP_REG_TO_DIR) begin
            next_cur.iram = '{en: 1'b1, wr: 1'b1, addr: INSTR_BYTE, wdata: bank_a};
            next_cur.ready = 1'b0;
            next_cur.st    = data_move_pkg::ST_WAIT;
          end else if (cur.opcode[7:1] == data_move_pkg::GRP_IND_TO_DIR) begin
            next_cur.iram  = '{en: 1'b1, wr: 1'b0, addr: bank_b, wdata: data_move_pkg::BYTE_ZERO};
            next_cur.ready = 1'b0;
            next_cur.st    = data_move_pkg::ST_READ;
          end else if (cur.opcode[7:3] == data_move_pkg::GRP_DIR_TO_REG
                       || cur.opcode == data_move_pkg::OP_BIT_TO_CARRY
                       || cur.opcode == data_move_pkg::OP_CARRY_TO_BIT) begin
            next_cur.iram.en   = 1'b1;
            next_cur.iram.addr = cur.opcode[7] && !cur.opcode[3] && cur.opcode[1] ? bit_to_byte(INSTR_BYTE) : INSTR_BYTE;
            next_cur.ready     = 1'b0;
            next_cur.st        = data_move_pkg::ST_READ;
          end else begin
            next_cur.st = data_move_pkg::ST_OPERAND2; // pointer load, immediate store, direct move
          end
        end
      end
      data_move_pkg::ST_OPERAND2: begin
        next_cur.ready = 1'b1;
        if (INSTR_VALID && cur.ready) begin
          next_cur.ready = 1'b0;
          next_cur.st    = data_move_pkg::ST_WAIT;
          if (cur.opcode == data_move_pkg::OP_PTR_LOAD) begin
            next_cur.ptr = {cur.op1, INSTR_BYTE};
          end else if (cur.opcode == data_move_pkg::OP_IMM_TO_DIRECT) begin
            next_cur.iram = '{en: 1'b1, wr: 1'b1, addr: cur.op1, wdata: INSTR_BYTE};
          end else begin
            next_cur.iram  = '{en: 1'b1, wr: 1'b0, addr: INSTR_BYTE, wdata: data_move_pkg::BYTE_ZERO};
            next_cur.val   = cur.op1; // destination kept until source byte returns
            next_cur.st    = data_move_pkg::ST_WRITE;
          end
        end
      end
      data_move_pkg::ST_READ: begin
        next_cur.ready = 1'b0;
        next_cur.st    = data_move_pkg::ST_WAIT;
        if (cur.opcode == data_move_pkg::OP_BIT_TO_CARRY) begin
          next_cur.carry = IRAM_RDATA[bit_pos];
          next_cur.ready = 1'b1;
          next_cur.done  = 1'b1;
          next_cur.st    = data_move_pkg::ST_OPCODE;
        end else if (cur.opcode == data_move_pkg::OP_CARRY_TO_BIT) begin
          next_cur.iram = '{en: 1'b1, wr: 1'b1, addr: bit_byte, wdata: IRAM_RDATA};
          next_cur.iram.wdata[bit_pos] = cur.carry;
        end else if (cur.opcode[7:1] == data_move_pkg::GRP_IND_TO_DIR) begin
          next_cur.iram = '{en: 1'b1, wr: 1'b1, addr: cur.op1, wdata: IRAM_RDATA};
        end else begin
          next_cur.bank_we    = 1'b1;
          next_cur.bank_widx  = cur.opcode[2:0];
          next_cur.bank_wdata = IRAM_RDATA;
        end
      end
      data_move_pkg::ST_WRITE: begin
        next_cur.ready = 1'b0;
        next_cur.iram  = '{en: 1'b1, wr: 1'b1, addr: cur.val, wdata: IRAM_RDATA};
        next_cur.st    = data_move_pkg::ST_WAIT;
      end
      data_move_pkg::ST_CODE: begin
        next_cur.ready = 1'b0;
        // address stays on the port pair until the code byte arrives
        if (CODE_VALID) begin
          next_cur.acc   = CODE_DATA;
          next_cur.done  = 1'b1;
          next_cur.ready = 1'b1;
          next_cur.st    = data_move_pkg::ST_OPCODE;
        end else begin
          next_cur.code_req = 1'b1;
        end
      end
      data_move_pkg::ST_EXT: begin
        next_cur.ready = 1'b1;
        next_cur.done  = 1'b1;
        next_cur.st    = data_move_pkg::ST_OPCODE;
      end
      data_move_pkg::ST_WAIT: begin
        next_cur.ready = 1'b1;
        next_cur.done  = 1'b1;
        next_cur.st    = data_move_pkg::ST_OPCODE;
      end
      default: begin
        next_cur.st = data_move_pkg::ST_OPCODE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      cur <= '{st: data_move_pkg::ST_OPCODE, ptr: data_move_pkg::WORD_ZERO, pc: data_move_pkg::WORD_ZERO,
               default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign INSTR_READY      = cur.ready;
  assign DONE             = cur.done;
  assign IRAM             = cur.iram;
  assign XBUS             = cur.xbus;
  assign CODE_REQ         = cur.code_req;
  assign ACC              = cur.acc;
  assign CARRY            = cur.carry;
  assign WIDE_POINTER_REG = cur.ptr;
  assign PC_OUT           = cur.pc;
  assign PC_LOAD          = cur.pc_load;

  chk_ptr_load_order: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (cur.st == data_move_pkg::ST_OPERAND2 && cur.opcode == data_move_pkg::OP_PTR_LOAD && INSTR_VALID && cur.ready)
    |=> WIDE_POINTER_REG == {$past(cur.op1), $past(INSTR_BYTE)}) else $error("pointer load order wrong");
  chk_acc_to_reg: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (cur.st == data_move_pkg::ST_OPCODE && INSTR_VALID && cur.ready && INSTR_BYTE[7:3] == data_move_pkg::GRP_ACC_TO_REG)
    |=> cur.bank_we && cur.bank_wdata == $past(ACC)) else $error("acc to register not written");
  chk_ext_ports: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (XBUS.en && XBUS.wr) |-> {XBUS.hi, XBUS.lo} == WIDE_POINTER_REG && XBUS.wdata == ACC)
    else $error("external write address wrong");
  chk_ext_done: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (XBUS.en && XBUS.wr) |=> DONE) else $error("external write not finished in two cycles");
  chk_lookup_pc: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (cur.st == data_move_pkg::ST_OPCODE && INSTR_VALID && cur.ready && INSTR_BYTE == data_move_pkg::OP_LOOKUP_PC)
    |=> PC_LOAD && {XBUS.hi, XBUS.lo} == $past(PC_IN) + data_move_pkg::PC_STEP + 16'($past(ACC)))
    else $error("pc lookup address");
  chk_lookup_load: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (cur.st == data_move_pkg::ST_CODE && CODE_VALID) |=> ACC == $past(CODE_DATA) && DONE) else $error("lookup load");
  chk_carry_stable: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (cur.opcode != data_move_pkg::OP_BIT_TO_CARRY) |=> $stable(CARRY)) else $error("carry changed");
  chk_acc_direct: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (cur.st == data_move_pkg::ST_OPERAND1 && cur.opcode == data_move_pkg::OP_ACC_TO_DIRECT && INSTR_VALID && cur.ready)
    |=> IRAM.en && IRAM.wr && IRAM.addr == $past(INSTR_BYTE) && IRAM.wdata == ACC && DONE) else $error("acc store");
  chk_imm_reg: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (cur.st == data_move_pkg::ST_OPERAND1 && cur.opcode[7:3] == data_move_pkg::GRP_IMM_TO_REG && INSTR_VALID
     && cur.ready)
    |=> cur.bank_we && cur.bank_wdata == $past(INSTR_BYTE)) else $error("immediate to register");
  cov_ext_write: cover property (@(posedge CLOCK) XBUS.en && XBUS.wr);
  cov_lookup: cover property (@(posedge CLOCK) cur.st == data_move_pkg::ST_CODE && CODE_VALID);
  cov_bit_carry: cover property (@(posedge CLOCK) cur.st == data_move_pkg::ST_READ
    && cur.opcode == data_move_pkg::OP_BIT_TO_CARRY);
endmodule
